// file: verilog/smd_pkg.sv
// Shared constants and types for the strap mode decode and LED logic.
package smd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Strap codes, bit 3 down to 0: test, clock, input, execute.
  localparam int          SMD_STRAP_W       = 4;
  localparam logic [3:0]  SMD_CODE_MODE0    = 4'h0;
  localparam logic [3:0]  SMD_CODE_MODE1    = 4'h3;
  localparam logic [3:0]  SMD_CODE_ISOLATE  = 4'h7;
  localparam logic [3:0]  SMD_CODE_XOR      = 4'h8;
  localparam logic [3:0]  SMD_CODE_MODE2    = 4'h9;
  localparam logic [3:0]  SMD_CODE_TESTING  = 4'ha;
  localparam logic [3:0]  SMD_CODE_MODE3    = 4'hb;
  localparam logic [3:0]  SMD_CODE_MODE4    = 4'hc;
  localparam logic [3:0]  SMD_CODE_RSVD     = 4'hd;
  localparam logic [3:0]  SMD_CODE_RSVD_TST = 4'he;
  localparam logic [3:0]  SMD_CODE_PWRDN    = 4'hf;

  typedef enum logic [3:0] {
    SMD_M_MODE0    = 4'h0,
    SMD_M_MODE1    = 4'h1,
    SMD_M_MODE2    = 4'h2,
    SMD_M_MODE3    = 4'h3,
    SMD_M_MODE4    = 4'h4,
    SMD_M_ISOLATE  = 4'h5,
    SMD_M_TESTING  = 4'h6,
    SMD_M_XOR      = 4'h7,
    SMD_M_RSVD     = 4'h8,
    SMD_M_RSVD_TST = 4'h9,
    SMD_M_PWRDN    = 4'ha,
    SMD_M_ILLEGAL  = 4'hb
  } smd_mode_t;

  typedef enum logic [1:0] {
    SMD_LED_A = 2'h0,
    SMD_LED_B = 2'h1,
    SMD_LED_C = 2'h2
  } smd_led_cfg_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register port: byte addresses, field positions and reset values.
  localparam int          SMD_AW            = 8;
  localparam int          SMD_DW            = 32;
  localparam logic [7:0]  SMD_REG_STATUS    = 8'h00;
  localparam logic [7:0]  SMD_REG_CONTROL   = 8'h04;
  localparam logic [7:0]  SMD_REG_EVENT     = 8'h08;
  localparam logic [7:0]  SMD_REG_LINK      = 8'h0c;
  localparam int          SMD_ST_MODE_LSB   = 0;
  localparam int          SMD_ST_CODE_LSB   = 4;
  localparam int          SMD_ST_CFG_LSB    = 8;
  localparam int          SMD_ST_ENH_BIT    = 10;
  localparam int          SMD_ST_SPD_BIT    = 11;
  localparam int          SMD_ST_PD_BIT     = 12;
  localparam int          SMD_ST_TRI_BIT    = 13;
  localparam int          SMD_ST_VALID_BIT  = 14;
  localparam int          SMD_ST_STATE_LSB  = 16;
  localparam int          SMD_CT_LEDOFF_BIT = 0;
  localparam int          SMD_CT_LAMP_BIT   = 1;
  localparam int          SMD_EV_OFF_BIT    = 0;
  localparam int          SMD_EV_ON_BIT     = 1;
  localparam int          SMD_EV_CNT_LSB    = 8;
  localparam logic [1:0]  SMD_CTRL_RST      = 2'h0;
  localparam logic [1:0]  SMD_EVENT_RST     = 2'h0;
  localparam logic [7:0]  SMD_CNT_RST       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: activity lamp hold time per blink phase.
  localparam int          SMD_CLK_HZ        = 25_000_000;
  localparam int          SMD_ACT_HOLD_MS   = 30;
  localparam int          SMD_ACT_HOLD_CYC  = SMD_CLK_HZ / 1000 * SMD_ACT_HOLD_MS;

endpackage

// file: verilog/smd_strap_latch.sv
// Strap capture at reset release and decode into the operating mode.
`timescale 1ns/1ps
`default_nettype none
module smd_strap_latch
  import smd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] strap_code,
  output logic      [3:0] code_r,
  output smd_mode_t       mode_r,
  output logic            valid_r
);

  logic      [3:0] code_nxt;
  smd_mode_t       mode_nxt;
  logic            taken_r;
  logic            taken_nxt;
  logic            valid_nxt;

  function automatic smd_mode_t decode(input logic [3:0] c);
    case (c)
      SMD_CODE_MODE0:    decode = SMD_M_MODE0;
      SMD_CODE_MODE1:    decode = SMD_M_MODE1;
      SMD_CODE_MODE2:    decode = SMD_M_MODE2;
      SMD_CODE_MODE3:    decode = SMD_M_MODE3;
      SMD_CODE_MODE4:    decode = SMD_M_MODE4;
      SMD_CODE_ISOLATE:  decode = SMD_M_ISOLATE;
      SMD_CODE_TESTING:  decode = SMD_M_TESTING;
      SMD_CODE_XOR:      decode = SMD_M_XOR;
      SMD_CODE_RSVD:     decode = SMD_M_RSVD;
      SMD_CODE_RSVD_TST: decode = SMD_M_RSVD_TST;
      SMD_CODE_PWRDN:    decode = SMD_M_PWRDN;
      default:           decode = SMD_M_ILLEGAL;
    endcase
  endfunction

  // The async reset may only load constants, so the straps are taken at
  // the first edge after release and then frozen until the next reset.
  always_comb begin
    code_nxt  = code_r;
    mode_nxt  = mode_r;
    taken_nxt = 1'b1;
    valid_nxt = taken_r;
    if (!taken_r) begin
      code_nxt = strap_code;
      mode_nxt = decode(strap_code);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_r  <= 4'h0;
      mode_r  <= SMD_M_ILLEGAL;
      taken_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      code_r  <= code_nxt;
      mode_r  <= mode_nxt;
      taken_r <= taken_nxt;
      valid_r <= valid_nxt;
    end
  end

endmodule
`default_nettype wire

// file: verilog/smd_led_drive.sv
// Active-low LED drivers for the three LED configurations.
`timescale 1ns/1ps
`default_nettype none
module smd_led_drive
  import smd_pkg::*;
#(
  parameter int unsigned HOLD_CYC = SMD_ACT_HOLD_CYC
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire smd_led_cfg_t led_cfg,
  input  wire logic         link_up,
  input  wire logic         speed100,
  input  wire logic         activity,
  input  wire logic         blank,
  input  wire logic         lamp_test,
  output logic              activity_led_n,
  output logic              speed_led_n,
  output logic              link_led_n
);

  localparam int CW = $clog2(2 * HOLD_CYC + 1);
  localparam logic [CW-1:0] FULL = CW'(2 * HOLD_CYC);
  localparam logic [CW-1:0] HALF = CW'(HOLD_CYC);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          act_on;
  logic          spd_on;
  logic          lnk_on;
  logic          act_n_nxt;
  logic          spd_n_nxt;
  logic          lnk_n_nxt;

  // Activity gives an on phase then a forced off phase, so steady traffic
  // flickers the lamp instead of holding it solidly lit.
  always_comb begin
    cnt_nxt = cnt_r;
    if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CW'(1);
    end else if (activity) begin
      cnt_nxt = FULL;
    end
    act_on = cnt_r > HALF;
    spd_on = speed100;
    lnk_on = link_up;
    case (led_cfg)
      SMD_LED_A: spd_on = speed100;
      SMD_LED_B: spd_on = link_up & speed100;
      SMD_LED_C: begin
        spd_on = link_up & speed100;
        lnk_on = link_up & ~speed100;
      end
      default: spd_on = speed100;
    endcase
    act_n_nxt = ~((act_on & ~blank) | lamp_test);
    spd_n_nxt = ~((spd_on & ~blank) | lamp_test);
    lnk_n_nxt = ~((lnk_on & ~blank) | lamp_test);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r          <= '0;
      activity_led_n <= 1'b1;
      speed_led_n    <= 1'b1;
      link_led_n     <= 1'b1;
    end else begin
      cnt_r          <= cnt_nxt;
      activity_led_n <= act_n_nxt;
      speed_led_n    <= spd_n_nxt;
      link_led_n     <= lnk_n_nxt;
    end
  end

endmodule
`default_nettype wire

// file: verilog/smd_strap_mode_top.sv
// Top level: strap mode decode, power and pad control, LEDs and registers.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Code 1101 is reserved; no operating mode, pads tri-stated, fault shown.
// - Code 1110 is a reserved test state; treated as halted, fault shown.
// - Code 1111 is power-down: pads tri-stated and core powered down.
// - Activity LED shows activity; in A and B link LED shows any link.
// - Speed LED shows 100 Mb in A; link and 100 Mb in B and C.
// - In configuration C the link LED shows link at 10 Mb only.
// - Mode 1 uses LED configuration B and single-pin Shared_disable_pin_n.
// - Mode 2 equals mode 1 but LEDs follow configuration C.
// - Mode 3 is configuration B, single-pin disable and enhanced transmit.
// - Mode 4 equals mode 3 but LEDs follow configuration C.
// - Code 0011 is mode 1; disable pin low tri-states and powers down.
// - Code 1001 selects mode 2.
// - Code 1011 selects mode 3.
// - Code 1100 selects mode 4.
////////////////////////////////////////////////////////////////////////////////
module smd_strap_mode_top
  import smd_pkg::*;
#(
  parameter int unsigned ACT_HOLD_CYC = SMD_ACT_HOLD_CYC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              test_strap,
  input  wire logic              strap_clock_pin,
  input  wire logic              strap_input_pin,
  input  wire logic              strap_execute_pin,
  input  wire logic              shared_disable_pin_n,
  input  wire logic              link_up,
  input  wire logic              link_speed100,
  input  wire logic              activity,
  input  wire logic [SMD_AW-1:0] reg_addr,
  input  wire logic [SMD_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [SMD_DW-1:0] reg_rdata,
  output logic                   activity_led_n,
  output logic                   speed_led_n,
  output logic                   link_led_n,
  output logic                   pad_oe_n,
  output logic                   power_down,
  output logic                   advertise_ten_only,
  output logic                   enhanced_tx,
  output logic                   xor_tree_en,
  output logic                   test_mode_en,
  output logic                   mode_fault
);

  typedef enum logic [2:0] {
    SMD_ST_WAIT    = 3'h0,
    SMD_ST_RUN     = 3'h1,
    SMD_ST_LAN_OFF = 3'h2,
    SMD_ST_ISOLATE = 3'h3,
    SMD_ST_XOR     = 3'h4,
    SMD_ST_TEST    = 3'h5,
    SMD_ST_HALT    = 3'h6
  } smd_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Mode property lookups, shared by the pad control and the status word.

  function automatic smd_led_cfg_t cfg_of(input smd_mode_t m);
    case (m)
      SMD_M_MODE1: cfg_of = SMD_LED_B;
      SMD_M_MODE2: cfg_of = SMD_LED_C;
      SMD_M_MODE3: cfg_of = SMD_LED_B;
      SMD_M_MODE4: cfg_of = SMD_LED_C;
      default:     cfg_of = SMD_LED_A;
    endcase
  endfunction

  function automatic logic single_pin_of(input smd_mode_t m);
    case (m)
      SMD_M_MODE1: single_pin_of = 1'b1;
      SMD_M_MODE2: single_pin_of = 1'b1;
      SMD_M_MODE3: single_pin_of = 1'b1;
      SMD_M_MODE4: single_pin_of = 1'b1;
      default:     single_pin_of = 1'b0;
    endcase
  endfunction

  function automatic logic enh_tx_of(input smd_mode_t m);
    case (m)
      SMD_M_MODE3: enh_tx_of = 1'b1;
      SMD_M_MODE4: enh_tx_of = 1'b1;
      default:     enh_tx_of = 1'b0;
    endcase
  endfunction

  function automatic smd_state_t entry_of(input smd_mode_t m);
    case (m)
      SMD_M_MODE0:    entry_of = SMD_ST_RUN;
      SMD_M_MODE1:    entry_of = SMD_ST_RUN;
      SMD_M_MODE2:    entry_of = SMD_ST_RUN;
      SMD_M_MODE3:    entry_of = SMD_ST_RUN;
      SMD_M_MODE4:    entry_of = SMD_ST_RUN;
      SMD_M_ISOLATE:  entry_of = SMD_ST_ISOLATE;
      SMD_M_PWRDN:    entry_of = SMD_ST_ISOLATE;
      SMD_M_XOR:      entry_of = SMD_ST_XOR;
      SMD_M_TESTING:  entry_of = SMD_ST_TEST;
      SMD_M_RSVD:     entry_of = SMD_ST_HALT;
      SMD_M_RSVD_TST: entry_of = SMD_ST_HALT;
      default:        entry_of = SMD_ST_HALT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and LED drivers.

  logic [3:0]   strap_code;
  logic [3:0]   code_r;
  smd_mode_t    mode_r;
  logic         strap_valid;
  smd_led_cfg_t led_cfg;
  logic         leds_blank;

  // The first edge after release captures the straps, so a strap change
  // later on, even a glitch, never moves the mode.
  assign strap_code = {test_strap, strap_clock_pin, strap_input_pin, strap_execute_pin};

  smd_strap_latch u_latch (
    .clk        (clk),
    .arst_n     (arst_n),
    .strap_code (strap_code),
    .code_r     (code_r),
    .mode_r     (mode_r),
    .valid_r    (strap_valid)
  );

  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;

  assign led_cfg    = cfg_of(mode_r);
  assign leds_blank = pad_oe_n | ctrl_r[SMD_CT_LEDOFF_BIT];

  smd_led_drive #(
    .HOLD_CYC (ACT_HOLD_CYC)
  ) u_led (
    .clk            (clk),
    .arst_n         (arst_n),
    .led_cfg        (led_cfg),
    .link_up        (link_up),
    .speed100       (link_speed100),
    .activity       (activity),
    .blank          (leds_blank),
    .lamp_test      (ctrl_r[SMD_CT_LAMP_BIT] & ~pad_oe_n),
    .activity_led_n (activity_led_n),
    .speed_led_n    (speed_led_n),
    .link_led_n     (link_led_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operating state and pad control.

  smd_state_t state_r;
  smd_state_t state_nxt;
  logic       oe_n_nxt;
  logic       pd_nxt;
  logic       adv_nxt;
  logic       enh_nxt;
  logic       xor_nxt;
  logic       test_nxt;
  logic       fault_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SMD_ST_WAIT: begin
        if (strap_valid) begin
          state_nxt = entry_of(mode_r);
        end
      end
      SMD_ST_RUN: begin
        if (single_pin_of(mode_r) && !shared_disable_pin_n) begin
          state_nxt = SMD_ST_LAN_OFF;
        end
      end
      SMD_ST_LAN_OFF: begin
        if (shared_disable_pin_n) begin
          state_nxt = SMD_ST_RUN;
        end
      end
      // Isolate, board test and halted states are left only by reset.
      SMD_ST_ISOLATE: state_nxt = SMD_ST_ISOLATE;
      SMD_ST_XOR:     state_nxt = SMD_ST_XOR;
      SMD_ST_TEST:    state_nxt = SMD_ST_TEST;
      SMD_ST_HALT:    state_nxt = SMD_ST_HALT;
      default:        state_nxt = SMD_ST_WAIT;
    endcase
  end

  always_comb begin
    oe_n_nxt  = 1'b1;
    pd_nxt    = 1'b0;
    adv_nxt   = 1'b0;
    enh_nxt   = 1'b0;
    xor_nxt   = 1'b0;
    test_nxt  = 1'b0;
    fault_nxt = 1'b0;
    case (state_nxt)
      SMD_ST_WAIT: begin
        oe_n_nxt = 1'b1;
      end
      SMD_ST_RUN: begin
        oe_n_nxt = 1'b0;
        // In mode 0 the shared pin keeps its old meaning: high limits the
        // advertisement to 10 Mb only.
        adv_nxt  = (mode_r == SMD_M_MODE0) & shared_disable_pin_n;
        enh_nxt  = enh_tx_of(mode_r);
      end
      SMD_ST_LAN_OFF: begin
        oe_n_nxt = 1'b1;
        pd_nxt   = 1'b1;
      end
      SMD_ST_ISOLATE: begin
        oe_n_nxt = 1'b1;
        pd_nxt   = 1'b1;
      end
      SMD_ST_XOR: begin
        oe_n_nxt = 1'b1;
        xor_nxt  = 1'b1;
      end
      SMD_ST_TEST: begin
        oe_n_nxt = 1'b0;
        test_nxt = 1'b1;
      end
      SMD_ST_HALT: begin
        oe_n_nxt  = 1'b1;
        fault_nxt = 1'b1;
      end
      default: begin
        oe_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r            <= SMD_ST_WAIT;
      pad_oe_n           <= 1'b1;
      power_down         <= 1'b0;
      advertise_ten_only <= 1'b0;
      enhanced_tx        <= 1'b0;
      xor_tree_en        <= 1'b0;
      test_mode_en       <= 1'b0;
      mode_fault         <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      pad_oe_n           <= oe_n_nxt;
      power_down         <= pd_nxt;
      advertise_ten_only <= adv_nxt;
      enhanced_tx        <= enh_nxt;
      xor_tree_en        <= xor_nxt;
      test_mode_en       <= test_nxt;
      mode_fault         <= fault_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port: control, sticky disable events and read-back.

  logic              wr_ctrl;
  logic              wr_event;
  logic              off_evt;
  logic              on_evt;
  logic [1:0]        event_r;
  logic [1:0]        event_nxt;
  logic [7:0]        off_cnt_r;
  logic [7:0]        off_cnt_nxt;
  logic [SMD_DW-1:0] rdata_nxt;
  logic [SMD_DW-1:0] status_word;

  assign wr_ctrl  = reg_wr && (reg_addr == SMD_REG_CONTROL);
  assign wr_event = reg_wr && (reg_addr == SMD_REG_EVENT);
  assign off_evt  = (state_r == SMD_ST_RUN) && (state_nxt == SMD_ST_LAN_OFF);
  assign on_evt   = (state_r == SMD_ST_LAN_OFF) && (state_nxt == SMD_ST_RUN);

  always_comb begin
    ctrl_nxt    = ctrl_r;
    event_nxt   = event_r;
    off_cnt_nxt = off_cnt_r;
    if (wr_ctrl) begin
      ctrl_nxt = reg_wdata[1:0];
    end
    // Write-one clears; an event in the same cycle wins over the clear.
    if (wr_event) begin
      event_nxt = event_r & ~reg_wdata[1:0];
    end
    if (off_evt) begin
      event_nxt[SMD_EV_OFF_BIT] = 1'b1;
      if (off_cnt_r != 8'hff) begin
        off_cnt_nxt = off_cnt_r + 8'h01;
      end
    end
    if (on_evt) begin
      event_nxt[SMD_EV_ON_BIT] = 1'b1;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[SMD_ST_MODE_LSB +: 4]  = mode_r;
    status_word[SMD_ST_CODE_LSB +: 4]  = code_r;
    status_word[SMD_ST_CFG_LSB +: 2]   = led_cfg;
    status_word[SMD_ST_ENH_BIT]        = enhanced_tx;
    status_word[SMD_ST_SPD_BIT]        = single_pin_of(mode_r);
    status_word[SMD_ST_PD_BIT]         = power_down;
    status_word[SMD_ST_TRI_BIT]        = pad_oe_n;
    status_word[SMD_ST_VALID_BIT]      = strap_valid;
    status_word[SMD_ST_STATE_LSB +: 3] = state_r;
  end

  // Read data stand only in the cycle after the strobe, zero otherwise,
  // and an unmapped address also reads as zero.
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        SMD_REG_STATUS: begin
          rdata_nxt = status_word;
        end
        SMD_REG_CONTROL: begin
          rdata_nxt[1:0] = ctrl_r;
        end
        SMD_REG_EVENT: begin
          rdata_nxt[1:0]                  = event_r;
          rdata_nxt[SMD_EV_CNT_LSB +: 8]  = off_cnt_r;
        end
        SMD_REG_LINK: begin
          rdata_nxt[0] = link_up;
          rdata_nxt[1] = link_speed100;
          rdata_nxt[2] = activity_led_n;
          rdata_nxt[3] = speed_led_n;
          rdata_nxt[4] = link_led_n;
          rdata_nxt[5] = shared_disable_pin_n;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r    <= SMD_CTRL_RST;
      event_r   <= SMD_EVENT_RST;
      off_cnt_r <= SMD_CNT_RST;
      reg_rdata <= '0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      event_r   <= event_nxt;
      off_cnt_r <= off_cnt_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// file: bench/smd_strap_mode_props.sv
// Concurrent checks on the ports of the strap mode top level.
`timescale 1ns/1ps
`default_nettype none
module smd_strap_mode_props #(
  parameter int unsigned ACT_HOLD_CYC = 4
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        shared_disable_pin_n,
  input wire logic        link_up,
  input wire logic        link_speed100,
  input wire logic        activity,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        pad_oe_n,
  input wire logic        power_down,
  input wire logic        enhanced_tx,
  input wire logic        mode_fault,
  input wire logic        activity_led_n,
  input wire logic        speed_led_n,
  input wire logic        link_led_n
);
  logic        lamp_r;
  logic        lamp_nxt;
  logic [31:0] idle_r;
  logic [31:0] idle_nxt;
  // Lamp test lights every lamp while the pads are driven, so the dark checks step aside while it is on.
  always_comb begin
    lamp_nxt = (reg_wr && reg_addr == 8'h04) ? reg_wdata[1] : lamp_r;
    idle_nxt = activity ? 32'h0 : idle_r + {31'h0, idle_r != 32'hffffffff};
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lamp_r <= 1'b0;
      idle_r <= 32'h0;
    end else begin
      lamp_r <= lamp_nxt;
      idle_r <= idle_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence dark_s;
    activity_led_n && speed_led_n && link_led_n;
  endsequence
  sequence lan_off_s;
    power_down && pad_oe_n;
  endsequence
  pwrdn_pads_a: assert property (power_down |-> pad_oe_n)
    else $error("pads driven while powered down");
  leds_dark_a: assert property (pad_oe_n |=> dark_s)
    else $error("lamp lit while pads released");
  fault_pads_a: assert property (mode_fault |-> pad_oe_n && !power_down)
    else $error("reserved code left pads driven");
  fault_held_a: assert property (mode_fault |=> mode_fault)
    else $error("fault cleared without reset");
  lan_off_a: assert property (enhanced_tx && !shared_disable_pin_n |=> lan_off_s)
    else $error("disable pin low did not power down");
  lan_back_a: assert property (enhanced_tx && shared_disable_pin_n |=> !power_down)
    else $error("enabled part stayed powered down");
  spd_dark_a: assert property (!link_speed100 && !lamp_r && !lamp_nxt |=> speed_led_n)
    else $error("speed lamp lit below 100 Mb");
  link_dark_a: assert property (!link_up && !lamp_r && !lamp_nxt |=> link_led_n)
    else $error("link lamp lit without link");
  act_dark_a: assert property (
    idle_r > ACT_HOLD_CYC + 1 && !lamp_r && !$past(lamp_r) |-> activity_led_n)
    else $error("activity lamp lit while idle");
endmodule
bind smd_strap_mode_top smd_strap_mode_props #(.ACT_HOLD_CYC(ACT_HOLD_CYC)) props_u (
  .clk(clk), .arst_n(arst_n), .shared_disable_pin_n(shared_disable_pin_n),
  .link_up(link_up), .link_speed100(link_speed100), .activity(activity),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pad_oe_n(pad_oe_n),
  .power_down(power_down), .enhanced_tx(enhanced_tx), .mode_fault(mode_fault),
  .activity_led_n(activity_led_n), .speed_led_n(speed_led_n), .link_led_n(link_led_n));
`default_nettype wire

// file: bench/smd_board_model.sv
// Board side: strap resistors and the three indicator lamps.
`timescale 1ns/1ps
`default_nettype none
module smd_board_model (
  input  wire logic [3:0] code,
  output logic            test_strap,
  output logic            strap_clock_pin,
  output logic            strap_input_pin,
  output logic            strap_execute_pin,
  input  wire logic       activity_led_n,
  input  wire logic       speed_led_n,
  input  wire logic       link_led_n,
  output logic      [2:0] lit
);
  // Straps are fitted resistors, so they never float; the code list is the bench's.
  assign {test_strap, strap_clock_pin, strap_input_pin, strap_execute_pin} = code;
  // A lamp glows while its pin sinks current.
  assign lit = ~{activity_led_n, speed_led_n, link_led_n};
endmodule
`default_nettype wire

// file: bench/strap_mode_decode_led_logic_tb.sv
// Self-checking bench for the strap mode decode and LED logic.
`timescale 1ns/1ps
`default_nettype none
module strap_mode_decode_led_logic_tb;
  localparam int unsigned HOLD = 4;
  logic clk = 1'b0, arst_n = 1'b0, shared_disable_pin_n = 1'b1;
  logic link_up = 1'b0, link_speed100 = 1'b0, activity = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] code = 4'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic test_strap, strap_clock_pin, strap_input_pin, strap_execute_pin;
  logic activity_led_n, speed_led_n, link_led_n, pad_oe_n, power_down, advertise_ten_only;
  logic enhanced_tx, xor_tree_en, test_mode_en, mode_fault;
  logic [2:0] lit;
  int mismatches = 0, n_compared = 0;
  logic [3:0] codes [12] = '{4'h0, 4'h3, 4'h9, 4'hb, 4'hc, 4'h7, 4'hf, 4'h8, 4'ha, 4'hd, 4'he, 4'h1};
  logic [3:0] modes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'ha, 4'h7, 4'h6, 4'h8, 4'h9, 4'hb};
  logic [6:0] outs [12] = '{7'h01, 7'h00, 7'h00, 7'h10, 7'h10, 7'h60, 7'h60, 7'h28, 7'h04,
                           7'h22, 7'h22, 7'h22};
  logic [3:0] cfgs [5] = '{4'h0, 4'h9, 4'ha, 4'hd, 4'he};
  smd_strap_mode_top #(.ACT_HOLD_CYC(HOLD)) dut_u (.clk, .arst_n, .test_strap, .strap_clock_pin,
    .strap_input_pin, .strap_execute_pin, .shared_disable_pin_n, .link_up, .link_speed100,
    .activity, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .activity_led_n,
    .speed_led_n, .link_led_n, .pad_oe_n, .power_down, .advertise_ten_only, .enhanced_tx,
    .xor_tree_en, .test_mode_en, .mode_fault);
  smd_board_model board_u (.code, .test_strap, .strap_clock_pin, .strap_input_pin,
    .strap_execute_pin, .activity_led_n, .speed_led_n, .link_led_n, .lit);
  always #20 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Every step ends settled at a falling edge; drivers start at the next rising one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic boot(input logic [3:0] c);
    @(posedge clk);
    code <= c;
    arst_n <= 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    cyc(5);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata & m, e);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 12; i++) begin
      boot(codes[i]);
      chk({power_down, pad_oe_n, enhanced_tx, xor_tree_en, test_mode_en, mode_fault,
           advertise_ten_only}, outs[i]);
      rd_chk(8'h00, 32'hf, modes[i]);
      if (i < 5) rd_chk(8'h00, 32'hf00, {cfgs[i], 8'h00});
      @(posedge clk);
      code <= ~codes[i];
      cyc(4);
      chk({power_down, pad_oe_n, enhanced_tx, xor_tree_en, test_mode_en, mode_fault,
           advertise_ten_only}, outs[i]);
    end
  endtask
  task automatic t_leds;
    logic l;
    logic s;
    for (int m = 0; m < 3; m++) begin
      boot(codes[m]);
      for (int k = 0; k < 4; k++) begin
        {l, s} = k[1:0];
        @(posedge clk);
        link_up <= l;
        link_speed100 <= s;
        cyc(2);
        chk(lit[1:0], m == 0 ? {s, l} : {l & s, m == 2 ? l & ~s : l});
      end
    end
  endtask
  task automatic t_act;
    int lit_n;
    boot(4'h3);
    chk(lit[2], 1'b0);
    @(posedge clk);
    activity <= 1'b1;
    @(posedge clk);
    activity <= 1'b0;
    lit_n = 0;
    repeat (4 * HOLD) begin
      @(negedge clk);
      lit_n += lit[2];
    end
    chk(lit_n, HOLD);
  endtask
  task automatic t_lan;
    boot(4'hb);
    @(posedge clk);
    link_up <= 1'b1;
    link_speed100 <= 1'b1;
    cyc(2);
    chk(lit, 3'h3);
    rd_chk(8'h0c, 32'h3f, 32'h27);
    @(posedge clk);
    shared_disable_pin_n <= 1'b0;
    cyc(2);
    chk({power_down, pad_oe_n, lit}, 5'h18);
    rd_chk(8'h08, 32'hff03, 32'h0101);
    @(posedge clk);
    shared_disable_pin_n <= 1'b1;
    cyc(2);
    chk({power_down, pad_oe_n, lit}, 5'h03);
    rd_chk(8'h08, 32'hff03, 32'h0103);
    wr_reg(8'h08, 32'h3);
    rd_chk(8'h08, 32'hffffffff, 32'h100);
    wr_reg(8'h00, 32'hffffffff);
    rd_chk(8'h00, 32'hff, 32'hb3);
    rd_chk(8'h10, 32'hffffffff, 32'h0);
    rd_chk(8'h04, 32'hffffffff, 32'h0);
    wr_reg(8'h04, 32'h2);
    cyc(2);
    chk(lit, 3'h7);
    wr_reg(8'h04, 32'h1);
    cyc(2);
    chk(lit, 3'h0);
    wr_reg(8'h04, 32'h0);
  endtask
  task automatic close_out;
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    t_modes();
    t_leds();
    t_act();
    t_lan();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
